// ===== rtl/sld_map.svh
// Constants for the status LED pattern driver
`ifndef SLD_MAP_SVH
`define SLD_MAP_SVH
`define SLD_CLK_HZ 125000000
`define SLD_HALF_1HZ_MS 500
`define SLD_HALF_2HZ_MS 250
`define SLD_STARTUP_MIN_MS 3000
`define SLD_FLICK_MS 40
`define SLD_TICK_HZ 1000
`define SLD_DI_WIDTH 16
`define SLD_DO_WIDTH 12
`endif

// ===== rtl/sld_pkg.sv
// Types for the status LED pattern driver
package sld_pkg;
   typedef struct packed {
      logic powerOn;
      logic startup;
      logic startupDiag;
      logic run;
      logic runWarn;
      logic stopped;
      logic holdPoint;
      logic errorState;
      logic sysError;
      logic cardWrite;
      logic hwConfigLoad;
      logic blinkTest;
      logic cardAccess;
      logic overallResetRequest;
      logic overallResetBusy;
      logic overallResetDone;
      logic factoryBusy;
      logic factoryDone;
      logic fwAvailable;
      logic fwBusy;
      logic fwDone;
      logic fwFailed;
   } sld_state_t;

   typedef struct packed {
      logic green;
      logic yellow;
      logic red;
   } sld_bar_t;

   typedef enum logic [1:0] {
      SLD_OFF,
      SLD_ON,
      SLD_BLINK1,
      SLD_BLINK2
   } sld_pat_t;
endpackage

// ===== rtl/sld_status_led_driver.sv
// Status bar patterns and channel indicator LEDs
`timescale 1ns/1ns
`include "sld_map.svh"
module sld_status_led_driver #(
   parameter int DI_WIDTH = `SLD_DI_WIDTH,
   parameter int DO_WIDTH = `SLD_DO_WIDTH,
   parameter int CLK_HZ = `SLD_CLK_HZ,
   parameter int TICK_HZ = `SLD_TICK_HZ
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Core state flags and card activity pulses
   input sld_pkg::sld_state_t cpuState,
   input wire logic cardActivity,
   // Channel levels
   input wire logic [DI_WIDTH-1:0] inputLevels,
   input wire logic [DO_WIDTH-1:0] outputLevels,
   input wire logic outputFault,
   // LED outputs
   output sld_pkg::sld_bar_t statusBar,
   output logic [DI_WIDTH-1:0] inputLeds,
   output logic [DO_WIDTH-1:0] outputLeds,
   output logic outputFaultLed,
   output logic cardFlickerLed
);
   // ==========================================================
   // Timebase
   localparam int TICK_DIV = CLK_HZ / TICK_HZ;
   localparam int HALF1 = `SLD_HALF_1HZ_MS * TICK_HZ / 1000;
   localparam int HALF2 = `SLD_HALF_2HZ_MS * TICK_HZ / 1000;
   localparam int STARTUP_TICKS = `SLD_STARTUP_MIN_MS * TICK_HZ / 1000;
   localparam int FLICK_TICKS = `SLD_FLICK_MS * TICK_HZ / 1000;

   // 1 Hz is derived from 2 Hz, so the half periods must pair up
   if (TICK_DIV < 2 || HALF2 < 2 || FLICK_TICKS < 2 || DI_WIDTH < 1 ||
       DO_WIDTH < 1 || STARTUP_TICKS < 1 ||
       HALF1 != 2 * HALF2) begin : gBadParams
      $error("sld_status_led_driver: unusable parameters");
   end

   logic [31:0] divCnt_q;
   logic tick;
   logic [31:0] halfCnt_q;
   logic blink1_q, blink2_q;
   logic [31:0] startCnt_q;
   logic startHold;
   logic [31:0] flickCnt_q;
   logic flicker;

   assign tick = (divCnt_q == 32'(TICK_DIV - 1));

   always_ff @(posedge ref_clk) begin
      if (!rst_n)
         divCnt_q <= 32'h0;
      else if (tick)
         divCnt_q <= 32'h0;
      else
         divCnt_q <= divCnt_q + 32'h1;
   end

   // 2 Hz toggles each quarter second, 1 Hz each second toggle of 2 Hz
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         halfCnt_q <= 32'h0;
         blink1_q <= 1'b0;
         blink2_q <= 1'b0;
      end else if (tick) begin
         if (halfCnt_q == 32'(HALF2 - 1)) begin
            halfCnt_q <= 32'h0;
            blink2_q <= ~blink2_q;
            if (blink2_q)
               blink1_q <= ~blink1_q;
         end else begin
            halfCnt_q <= halfCnt_q + 32'h1;
         end
      end
   end

   // ==========================================================
   // Start-up minimum display time
   always_ff @(posedge ref_clk) begin
      if (!rst_n)
         startCnt_q <= 32'h0;
      else if (cpuState.startup && startCnt_q == 32'h0)
         startCnt_q <= 32'(STARTUP_TICKS);
      else if (tick && startCnt_q != 32'h0)
         startCnt_q <= startCnt_q - 32'h1;
   end
   assign startHold = cpuState.startup || (startCnt_q != 32'h0);

   // ==========================================================
   // Flicker: fast toggle while stretched card activity lasts
   always_ff @(posedge ref_clk) begin
      if (!rst_n)
         flickCnt_q <= 32'h0;
      else if (cardActivity)
         flickCnt_q <= 32'(FLICK_TICKS);
      else if (tick && flickCnt_q != 32'h0)
         flickCnt_q <= flickCnt_q - 32'h1;
   end
   // Period of four ticks, far above the 2 Hz blink
   assign flicker = (flickCnt_q != 32'h0) & halfCnt_q[1];

   // ==========================================================
   // Pattern selection by fixed priority
   sld_pkg::sld_bar_t bar_d;
   logic flickLed_d;
   logic cardAcc;

   assign cardAcc = cpuState.cardAccess;

   always_comb begin
      bar_d = '0;
      flickLed_d = 1'b0;
      if (cpuState.fwBusy) begin
         bar_d.yellow = cardAcc ? flicker : blink2_q;
      end else if (cpuState.fwFailed) begin
         bar_d.red = blink1_q;
      end else if (cpuState.fwDone) begin
         bar_d.red = blink1_q;
         bar_d.yellow = blink1_q;
      end else if (cpuState.fwAvailable) begin
         bar_d.red = blink1_q;
         bar_d.yellow = ~blink1_q;
      end else if (cpuState.factoryBusy) begin
         bar_d.yellow = blink2_q;
      end else if (cpuState.factoryDone) begin
         bar_d.red = blink1_q;
         bar_d.yellow = blink1_q;
      end else if (cpuState.overallResetBusy) begin
         bar_d.yellow = blink2_q;
      end else if (cpuState.overallResetRequest) begin
         bar_d.yellow = blink1_q;
      end else if (cpuState.overallResetDone) begin
         bar_d.yellow = 1'b1;
      end else if (cpuState.sysError || cpuState.cardWrite) begin
         bar_d.red = 1'b1;
         bar_d.yellow = 1'b1;
      end else if (cpuState.errorState) begin
         bar_d.red = 1'b1;
      end else if (cpuState.powerOn) begin
         bar_d.yellow = blink1_q;
      end else if (cpuState.hwConfigLoad) begin
         bar_d.yellow = blink2_q;
      end else if (cpuState.startupDiag) begin
         bar_d.red = blink1_q;
         bar_d.green = blink2_q;
      end else if (startHold) begin
         bar_d.green = blink2_q;
      end else if (cpuState.blinkTest) begin
         bar_d.green = blink1_q;
      end else if (cpuState.holdPoint) begin
         bar_d.red = 1'b1;
         bar_d.green = blink1_q;
      end else if (cpuState.run && cpuState.runWarn) begin
         bar_d.red = blink1_q;
         bar_d.green = cardAcc ? flicker : 1'b1;
      end else if (cpuState.run) begin
         bar_d.green = 1'b1;
         flickLed_d = cardAcc & flicker;
      end else if (cpuState.stopped) begin
         bar_d.yellow = cardAcc ? flicker : 1'b1;
      end
   end

   // ==========================================================
   // Registered LED outputs
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         statusBar <= '0;
         cardFlickerLed <= 1'b0;
      end else begin
         statusBar <= bar_d;
         cardFlickerLed <= flickLed_d;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         inputLeds <= '0;
         outputLeds <= '0;
         outputFaultLed <= 1'b0;
      end else begin
         inputLeds <= inputLevels;
         outputLeds <= outputLevels;
         outputFaultLed <= outputFault;
      end
   end

   // ==========================================================
   // Assertions
   // Flags that outrank a checked pattern
   logic resetBand;
   logic aboveErr;
   logic aboveRun;
   assign resetBand = cpuState.fwBusy || cpuState.fwFailed ||
      cpuState.fwDone || cpuState.fwAvailable || cpuState.factoryBusy ||
      cpuState.factoryDone || cpuState.overallResetBusy ||
      cpuState.overallResetRequest;
   assign aboveErr = resetBand || cpuState.overallResetDone ||
      cpuState.sysError || cpuState.cardWrite;
   assign aboveRun = aboveErr || cpuState.errorState || cpuState.powerOn ||
      cpuState.hwConfigLoad || cpuState.startupDiag || startHold ||
      cpuState.blinkTest || cpuState.holdPoint;

   property pStartHold;
      @(posedge ref_clk) disable iff (!rst_n)
      $fell(cpuState.startup) |-> startCnt_q != 32'h0;
   endproperty
   startup_hold_a: assert property (pStartHold)
      else $error("start-up hold released early");

   input_mirror_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      rst_n |=> inputLeds == $past(inputLevels))
      else $error("input LEDs do not follow inputs");

   output_mirror_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      rst_n |=> outputLeds == $past(outputLevels))
      else $error("output LEDs do not follow outputs");

   fault_led_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      rst_n |=> outputFaultLed == $past(outputFault))
      else $error("fault LED does not follow fault");

   error_red_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      rst_n && cpuState.errorState && !aboveErr |=> statusBar == 3'h1)
      else $error("error state without red alone");

   run_green_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      rst_n && cpuState.run && !cpuState.runWarn && !aboveRun |=>
      statusBar == 3'h4)
      else $error("clean run without steady green");

   stop_yellow_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      rst_n && cpuState.stopped && !cpuState.run && !cpuState.cardAccess &&
      !aboveRun |=> statusBar == 3'h2)
      else $error("plain stop without steady yellow");

   sys_error_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      rst_n && (cpuState.sysError || cpuState.cardWrite) && !resetBand &&
      !cpuState.overallResetDone |=> statusBar == 3'h3)
      else $error("system error without red and yellow");

   reset_done_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      rst_n && cpuState.overallResetDone && !resetBand |=>
      statusBar == 3'h2)
      else $error("finished overall reset without steady yellow");

   flick_led_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      cardFlickerLed |-> statusBar == 3'h4)
      else $error("second green flickers outside clean run");

   fw_alt_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (cpuState.fwAvailable && !cpuState.fwBusy && !cpuState.fwDone &&
       !cpuState.fwFailed) |-> bar_d.red != bar_d.yellow)
      else $error("firmware pattern not alternating");

   fw_busy_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      cpuState.fwBusy |-> !bar_d.red && !bar_d.green)
      else $error("update pattern overridden");

   blink_two_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      $changed(blink1_q) |-> $changed(blink2_q))
      else $error("1 Hz not aligned to 2 Hz");

   cover_run_c: cover property (@(posedge ref_clk) cpuState.run);
   cover_flick_c: cover property (@(posedge ref_clk) flicker);
   cover_fw_c: cover property (@(posedge ref_clk) cpuState.fwDone);
   cover_hold_c: cover property (@(posedge ref_clk)
      startHold && !cpuState.startup);
endmodule

// ===== verif/sld_status_led_driver_tb.sv
// Self-checking testbench for the status LED pattern driver
`timescale 1ns/1ns
module tb;
   // ==========================================================
   // Stimulus and observed signals
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   sld_pkg::sld_state_t st = '0;
   logic cardActivity = 1'b0;
   logic [15:0] inputLevels = '0;
   logic [11:0] outputLevels = '0;
   logic outputFault = 1'b0;
   sld_pkg::sld_bar_t statusBar;
   logic [15:0] inputLeds;
   logic [11:0] outputLeds;
   logic outputFaultLed;
   logic cardFlickerLed;
   int errors = 0;
   int checked = 0;

   always #4 ref_clk = ~ref_clk;

   // Four cycles per tick: 1 Hz half period 2000, 2 Hz 1000 cycles
   sld_status_led_driver #(.CLK_HZ(4000), .TICK_HZ(1000)) dut (
      .ref_clk(ref_clk), .rst_n(rst_n), .cpuState(st),
      .cardActivity(cardActivity), .inputLevels(inputLevels),
      .outputLevels(outputLevels), .outputFault(outputFault),
      .statusBar(statusBar), .inputLeds(inputLeds),
      .outputLeds(outputLeds), .outputFaultLed(outputFaultLed),
      .cardFlickerLed(cardFlickerLed)
   );

   // ==========================================================
   // Shared tasks
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wt(int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task automatic go(sld_pkg::sld_state_t v);
      @(posedge ref_clk);
      st <= v;
   endtask

   task automatic sty(sld_pkg::sld_state_t v, logic [2:0] e);
      go(v);
      wt(3);
      chk("bar", statusBar, e);
   endtask

   // Times one full half period of a bar colour
   task automatic m(sld_pkg::sld_state_t v, int b, int half);
      logic p;
      int n;
      go(v);
      wt(2);
      for (int k = 0; k < 2; k++) begin
         p = statusBar[b];
         n = 0;
         while (statusBar[b] === p && n < 5000) begin
            wt(1);
            n++;
         end
      end
      chk("half period", n >= half - 8 && n <= half + 8, 1);
   endtask

   // Counts LED changes while card activity pulses arrive
   task automatic flk(sld_pkg::sld_state_t v, output int n);
      logic [3:0] p;
      go(v);
      #1;
      n = 0;
      p = {statusBar, cardFlickerLed};
      for (int i = 0; i < 200; i++) begin
         @(posedge ref_clk);
         cardActivity <= (i % 8 == 0);
         #1;
         if ({statusBar, cardFlickerLed} !== p) n++;
         p = {statusBar, cardFlickerLed};
      end
   endtask

   task automatic final_report();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_mirror();
      @(posedge ref_clk);
      inputLevels <= 16'ha5c3;
      outputLevels <= 12'h9e1;
      outputFault <= 1'b1;
      wt(1);
      chk("inputLeds", inputLeds, 16'ha5c3);
      chk("outputLeds", outputLeds, 12'h9e1);
      chk("outputFaultLed", outputFaultLed, 1'b1);
      @(posedge ref_clk);
      inputLevels <= 16'h5a3c;
      outputLevels <= 12'h61e;
      outputFault <= 1'b0;
      wt(1);
      chk("inputLeds", inputLeds, 16'h5a3c);
      chk("outputLeds", outputLeds, 12'h61e);
      chk("outputFaultLed", outputFaultLed, 1'b0);
   endtask

   task automatic t_steady();
      sty('{stopped: 1, default: 0}, 3'b010);
      sty('{errorState: 1, default: 0}, 3'b001);
      sty('{run: 1, default: 0}, 3'b100);
      sty('{run: 1, errorState: 1, default: 0}, 3'b001);
      sty('{sysError: 1, stopped: 1, default: 0}, 3'b011);
      sty('{cardWrite: 1, default: 0}, 3'b011);
      sty('{overallResetDone: 1, default: 0}, 3'b010);
   endtask

   task automatic t_blink();
      m('{powerOn: 1, default: 0}, 1, 2000);
      m('{hwConfigLoad: 1, default: 0}, 1, 1000);
      m('{run: 1, runWarn: 1, default: 0}, 0, 2000);
      chk("green", statusBar.green, 1);
      m('{holdPoint: 1, default: 0}, 2, 2000);
      chk("red", statusBar.red, 1);
      m('{startupDiag: 1, default: 0}, 0, 2000);
      m('{startupDiag: 1, default: 0}, 2, 1000);
      m('{blinkTest: 1, default: 0}, 2, 2000);
      m('{overallResetRequest: 1, default: 0}, 1, 2000);
      m('{overallResetBusy: 1, default: 0}, 1, 1000);
      m('{factoryBusy: 1, default: 0}, 1, 1000);
      m('{factoryDone: 1, default: 0}, 0, 2000);
      chk("yellow", statusBar.yellow, statusBar.red);
      m('{fwAvailable: 1, default: 0}, 0, 2000);
      chk("alternate", statusBar.yellow ^ statusBar.red, 1);
      m('{fwBusy: 1, default: 0}, 1, 1000);
      m('{fwDone: 1, default: 0}, 0, 2000);
      chk("yellow", statusBar.yellow, statusBar.red);
      m('{fwFailed: 1, default: 0}, 0, 2000);
      chk("yellow", statusBar.yellow, 0);
   endtask

   task automatic t_flick();
      int n;
      flk('{stopped: 1, cardAccess: 1, default: 0}, n);
      chk("flicker", n > 5, 1);
      flk('{run: 1, cardAccess: 1, default: 0}, n);
      chk("flicker", n > 5, 1);
      chk("bar", statusBar, 3'b100);
      flk('{run: 1, runWarn: 1, cardAccess: 1, default: 0}, n);
      chk("flicker", n > 5, 1);
      flk('{fwBusy: 1, cardAccess: 1, default: 0}, n);
      chk("flicker", n > 5, 1);
   endtask

   // Start-up ends early; green keeps blinking until the hold expires
   task automatic t_startup();
      m('{startup: 1, default: 0}, 2, 1000);
      m('{run: 1, default: 0}, 2, 1000);
      wt(10500);
      sty('{run: 1, default: 0}, 3'b100);
   endtask

   // ==========================================================
   // Main sequence and watchdog
   initial begin
      wt(3);
      chk("reset", {statusBar, inputLeds, outputFaultLed}, '0);
      wt(2);
      @(posedge ref_clk);
      rst_n <= 1'b1;
      t_mirror();
      t_steady();
      t_blink();
      t_flick();
      t_startup();
      final_report();
   end

   initial begin
      repeat (90000) @(posedge ref_clk);
      errors++;
      final_report();
   end
endmodule
